// ===== dcm_defs.svh
`ifndef DCM_DEFS_SVH
`define DCM_DEFS_SVH

// Command field widths and toggle group count
`define DCM_ADDR_W 6
`define DCM_SEL_W 2
`define DCM_DATA_W 12
`define DCM_GRP_N 5

// Register select code of the special command space
`define DCM_SEL_SPECIAL 2'h0

// Special command addresses
`define DCM_SPC_NOP 6'h00
`define DCM_SPC_PWR_DOWN 6'h08
`define DCM_SPC_PWR_UP 6'h09
`define DCM_SPC_MON_SEL 6'h0a
`define DCM_SPC_CTRL 6'h0c

// Control word bit positions
`define DCM_CW_PD_HIZ 11
`define DCM_CW_REF_LVL 10
`define DCM_CW_BOOST 9
`define DCM_CW_REF_INT 8
`define DCM_CW_MON_EN 7
`define DCM_CW_THERM_EN 6
`define DCM_CW_UNUSED 5
`define DCM_CW_TOG_HI 4
`define DCM_CW_TOG_LO 0

// Monitor address field inside the data word
`define DCM_MON_HI 11
`define DCM_MON_LO 6

// Control word reset value, reference level bit patched per variant
`define DCM_CW_RESET 12'h800

// Monitor decode limits
`define DCM_MON_LAST_CH 6'h26
`define DCM_MON_HIZ 6'h3f

// Channels per toggle group, as a shift
`define DCM_GRP_SHIFT 3

`endif

// ===== dcm_pkg.sv
`default_nettype none
package dcm_pkg;
  // Power state of the output amplifiers
  typedef enum logic [1:0] {
    DCM_PWR_ON = 2'b00,
    DCM_PWR_SOFT_DOWN = 2'b01,
    DCM_PWR_THERMAL = 2'b10
  } dcm_pwr_t;
endpackage
`default_nettype wire

// ===== dcm_mon_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcm_mon_if;
  logic load;
  logic [5:0] addr;
  logic enable;
  logic route_on;
  logic pin_hiz;
  logic undefined;
  logic [5:0] channel;
  modport ctrl (
    output load,
    output addr,
    output enable,
    input route_on,
    input pin_hiz,
    input undefined,
    input channel
  );
  modport dec (
    input load,
    input addr,
    input enable,
    output route_on,
    output pin_hiz,
    output undefined,
    output channel
  );
endinterface
`default_nettype wire

// ===== dcm_mon_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcm_defs.svh"
module dcm_mon_dec (
  input wire logic core_clk,
  input wire logic rst,
  dcm_mon_if.dec mon
);
  typedef struct packed {
    logic [5:0] sel;
    logic route_on;
    logic pin_hiz;
    logic undefined;
  } dcm_mon_state_t;

  dcm_mon_state_t st;
  dcm_mon_state_t next_st;

  // Latch the selected address and decode the pin routing
  always_comb
  begin
    next_st = st;
    if (mon.load)
    begin
      next_st.sel = mon.addr;
    end
    // Pin is a plain output while monitoring is off
    next_st.route_on = mon.enable && (next_st.sel <= `DCM_MON_LAST_CH);
    next_st.pin_hiz = mon.enable && (next_st.sel == `DCM_MON_HIZ);
    next_st.undefined = mon.enable && (next_st.sel > `DCM_MON_LAST_CH)
      && (next_st.sel != `DCM_MON_HIZ);
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= '{sel: `DCM_MON_HIZ, route_on: 1'b0, pin_hiz: 1'b0, undefined: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign mon.route_on = st.route_on;
  assign mon.pin_hiz = st.pin_hiz;
  assign mon.undefined = st.undefined;
  assign mon.channel = st.sel;
endmodule
`default_nettype wire

// ===== dcm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcm_defs.svh"
module dcm_ctrl #(
  parameter int CHANNELS = 40,
  parameter logic REF_LEVEL_DEFAULT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_ab_b,
  input wire logic [5:0] cmd_addr,
  input wire logic [1:0] cmd_sel,
  input wire logic [11:0] cmd_data,
  input wire logic load_strobe_n,
  input wire logic hw_powerdown,
  input wire logic over_temp,
  output logic rd_valid,
  output logic [11:0] rd_data,
  output logic cmd_refused,
  output logic data_wr,
  output logic data_wr_b,
  output logic [5:0] data_wr_channel,
  output logic [1:0] data_wr_sel,
  output logic [11:0] data_wr_value,
  output logic amps_off,
  output logic powerdown_output_state_bit,
  output logic internal_ref_level_bit,
  output logic amp_boost_bit,
  output logic ref_source_bit,
  output logic monitor_enable_bit,
  output logic thermal_shutdown_enable_bit,
  output logic [4:0] toggle_group_enables,
  output logic [4:0] toggle_group_uses_b,
  output logic last_channel_output,
  output logic monitor_output_pin,
  output logic monitor_pin_hiz,
  output logic monitor_undefined,
  output logic [5:0] monitor_channel_address
);
  // Refuse channel counts that the toggle groups or address field cannot cover
  if (CHANNELS < 1 || CHANNELS > (`DCM_GRP_N << `DCM_GRP_SHIFT))
  begin : g_chk
    $error("dcm_ctrl: CHANNELS out of range");
  end
  // Toggle field must hold exactly one enable per group
  if (`DCM_GRP_N != `DCM_CW_TOG_HI - `DCM_CW_TOG_LO + 1)
  begin : g_chk_grp
    $error("dcm_ctrl: toggle field does not match group count");
  end

  typedef struct packed {
    logic [11:0] ctrl;
    dcm_pkg::dcm_pwr_t pwr;
    logic amps_off;
    logic strobe_q;
    logic [4:0] tog_b;
    logic rd_valid;
    logic [11:0] rd_data;
    logic refused;
    logic data_wr;
    logic data_wr_b;
    logic [5:0] data_ch;
    logic [1:0] data_sel;
    logic [11:0] data_val;
    logic mon_load;
    logic [5:0] mon_addr;
    logic last_ch_dac;
  } dcm_state_t;

  dcm_state_t st;
  dcm_state_t next_st;
  dcm_mon_if mon_bus ();

  // Toggle group of a channel, or none past the last channel
  function automatic logic [4:0] group_mask(input logic [5:0] ch);
    logic [4:0] m;
    logic [2:0] g;
    m = 5'h00;
    g = 3'(ch >> `DCM_GRP_SHIFT);
    if (int'(ch) < CHANNELS)
    begin
      m[g] = 1'b1;
    end
    return m;
  endfunction

  // Reset value of the control word with the variant reference level
  function automatic logic [11:0] ctrl_reset();
    logic [11:0] v;
    v = `DCM_CW_RESET;
    v[`DCM_CW_REF_LVL] = REF_LEVEL_DEFAULT;
    return v;
  endfunction

  // Toggle group enable field of a control word
  function automatic logic [4:0] tog_field(input logic [11:0] w);
    return w[`DCM_CW_TOG_HI:`DCM_CW_TOG_LO];
  endfunction

  logic is_special;
  logic is_write;
  logic powered_down;
  logic strobe_fall;

  // Command classification
  assign is_special = (cmd_sel == `DCM_SEL_SPECIAL);
  assign is_write = cmd_valid && !cmd_read;
  assign powered_down = st.amps_off || hw_powerdown; // Registered amps_off or the live hw_powerdown input
  assign strobe_fall = st.strobe_q && !load_strobe_n;

  // Command decode, power state and toggle tracking
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.refused = 1'b0;
    next_st.data_wr = 1'b0;
    next_st.mon_load = 1'b0;
    next_st.strobe_q = load_strobe_n;

    if (cmd_valid && is_special)
    begin
      case (cmd_addr)
        `DCM_SPC_CTRL:
        begin
          if (cmd_read)
          begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = st.ctrl;
          end
          else if (powered_down)
          begin
            next_st.refused = 1'b1;
          end
          else
          begin
            next_st.ctrl = cmd_data;
          end
        end
        `DCM_SPC_MON_SEL:
        begin
          if (is_write && powered_down)
          begin
            next_st.refused = 1'b1;
          end
          else if (is_write)
          begin
            next_st.mon_load = 1'b1;
            next_st.mon_addr = cmd_data[`DCM_MON_HI:`DCM_MON_LO];
          end
        end
        `DCM_SPC_PWR_DOWN:
        begin
          if (is_write)
          begin
            next_st.pwr = dcm_pkg::DCM_PWR_SOFT_DOWN;
          end
        end
        `DCM_SPC_PWR_UP:
        begin
          // Stays down while the die is still hot and thermal shutdown is enabled
          if (is_write && !(st.ctrl[`DCM_CW_THERM_EN] && over_temp))
          begin
            next_st.pwr = dcm_pkg::DCM_PWR_ON;
          end
        end
        `DCM_SPC_NOP:
        begin
          // No operation, state kept as is
          next_st.pwr = st.pwr;
        end
        default:
        begin
          next_st.pwr = st.pwr;
        end
      endcase
    end
    else if (is_write)
    begin
      // Data, offset or gain write passed on to the channel store, refused while powered down
      if (powered_down)
      begin
        next_st.refused = 1'b1;
      end
      else
      begin
        next_st.data_wr = 1'b1;
        next_st.data_ch = cmd_addr;
        next_st.data_sel = cmd_sel;
        next_st.data_val = cmd_data;
        next_st.data_wr_b = cmd_ab_b
          && |(group_mask(cmd_addr) & tog_field(st.ctrl));
      end
    end

    // Thermal shutdown overrides while powered
    if (next_st.pwr == dcm_pkg::DCM_PWR_ON && st.ctrl[`DCM_CW_THERM_EN] && over_temp)
    begin
      next_st.pwr = dcm_pkg::DCM_PWR_THERMAL;
    end
    next_st.amps_off = (next_st.pwr != dcm_pkg::DCM_PWR_ON) || hw_powerdown;

    // Load strobe swaps enabled groups; disabled groups fall back to A
    if (strobe_fall)
    begin
      next_st.tog_b = st.tog_b ^ tog_field(st.ctrl);
    end
    next_st.tog_b = next_st.tog_b & tog_field(next_st.ctrl);
    // Last channel stays a plain output unless monitoring is on
    next_st.last_ch_dac = !next_st.ctrl[`DCM_CW_MON_EN];
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st.ctrl <= ctrl_reset();
      st.pwr <= dcm_pkg::DCM_PWR_ON;
      st.amps_off <= 1'b0;
      st.strobe_q <= 1'b1;
      st.tog_b <= 5'h00;
      st.rd_valid <= 1'b0;
      st.rd_data <= 12'h000;
      st.refused <= 1'b0;
      st.data_wr <= 1'b0;
      st.data_wr_b <= 1'b0;
      st.data_ch <= 6'h00;
      st.data_sel <= 2'h0;
      st.data_val <= 12'h000;
      st.mon_load <= 1'b0;
      st.mon_addr <= 6'h00;
      st.last_ch_dac <= 1'b1; // Monitor is off after reset
    end
    else
    begin
      st <= next_st;
    end
  end

  // Monitor decoder link
  assign mon_bus.load = st.mon_load;
  assign mon_bus.addr = st.mon_addr;
  assign mon_bus.enable = st.ctrl[`DCM_CW_MON_EN];

  dcm_mon_dec i_dcm_mon_dec (
    .core_clk(core_clk),
    .rst(rst),
    .mon(mon_bus.dec)
  );

  // Register outputs
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign cmd_refused = st.refused;
  assign data_wr = st.data_wr;
  assign data_wr_b = st.data_wr_b;
  assign data_wr_channel = st.data_ch;
  assign data_wr_sel = st.data_sel;
  assign data_wr_value = st.data_val;
  assign amps_off = st.amps_off;

  // Control word fields
  assign powerdown_output_state_bit = st.ctrl[`DCM_CW_PD_HIZ];
  assign internal_ref_level_bit = st.ctrl[`DCM_CW_REF_LVL];
  assign amp_boost_bit = st.ctrl[`DCM_CW_BOOST];
  assign ref_source_bit = st.ctrl[`DCM_CW_REF_INT];
  assign monitor_enable_bit = st.ctrl[`DCM_CW_MON_EN];
  assign thermal_shutdown_enable_bit = st.ctrl[`DCM_CW_THERM_EN];
  assign toggle_group_enables = tog_field(st.ctrl);
  assign toggle_group_uses_b = st.tog_b;

  // Monitor pin routing
  assign last_channel_output = st.last_ch_dac;
  assign monitor_output_pin = mon_bus.route_on;
  assign monitor_pin_hiz = mon_bus.pin_hiz;
  assign monitor_undefined = mon_bus.undefined;
  assign monitor_channel_address = mon_bus.channel;
endmodule
`default_nettype wire

// ===== dcm_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dcm_ctrl_checker #(
  parameter int CHANNELS = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_ab_b,
  input wire logic [5:0] cmd_addr,
  input wire logic [1:0] cmd_sel,
  input wire logic [11:0] cmd_data,
  input wire logic load_strobe_n,
  input wire logic hw_powerdown,
  input wire logic over_temp,
  input wire logic rd_valid,
  input wire logic [11:0] rd_data,
  input wire logic cmd_refused,
  input wire logic data_wr,
  input wire logic data_wr_b,
  input wire logic amps_off,
  input wire logic powerdown_output_state_bit,
  input wire logic internal_ref_level_bit,
  input wire logic amp_boost_bit,
  input wire logic ref_source_bit,
  input wire logic monitor_enable_bit,
  input wire logic thermal_shutdown_enable_bit,
  input wire logic [4:0] toggle_group_enables,
  input wire logic [4:0] toggle_group_uses_b,
  input wire logic last_channel_output,
  input wire logic monitor_output_pin,
  input wire logic monitor_pin_hiz,
  input wire logic monitor_undefined,
  input wire logic [5:0] monitor_channel_address
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [10:0] ctrl_bits;
  logic blocked;
  // Stored word without the dead bit, and the write block condition
  assign ctrl_bits = {powerdown_output_state_bit, internal_ref_level_bit, amp_boost_bit,
    ref_source_bit, monitor_enable_bit, thermal_shutdown_enable_bit, toggle_group_enables};
  assign blocked = amps_off | hw_powerdown;
  // Special command shapes
  sequence ctrl_cmd;
    cmd_valid && cmd_sel == 2'h0 && cmd_addr == 6'h0c;
  endsequence
  sequence mon_cmd;
    cmd_valid && cmd_sel == 2'h0 && cmd_addr == 6'h0a && !cmd_read;
  endsequence
  ctrl_write_a: assert property (ctrl_cmd ##0 !cmd_read && !blocked |=>
    ctrl_bits == {$past(cmd_data[11:6]), $past(cmd_data[4:0])}) else $error("ctrl write lost");
  read_back_a: assert property (ctrl_cmd ##0 cmd_read |=> rd_valid &&
    {rd_data[11:6], rd_data[4:0]} == ctrl_bits) else $error("ctrl read wrong");
  write_refuse_a: assert property (ctrl_cmd ##0 !cmd_read && blocked |=>
    cmd_refused && $stable(ctrl_bits)) else $error("write taken in power-down");
  mon_select_a: assert property (mon_cmd ##0 !blocked |-> ##2
    monitor_channel_address == $past(cmd_data[11:6], 2)) else $error("monitor address lost");
  mon_route_a: assert property (monitor_output_pin |-> monitor_channel_address <= 6'h26
    && !monitor_pin_hiz && !monitor_undefined) else $error("route out of range");
  mon_hiz_a: assert property ($past(monitor_enable_bit) && monitor_channel_address == 6'h3f
    |-> monitor_pin_hiz && !monitor_output_pin) else $error("address 63 not hiz");
  mon_off_a: assert property (!$past(monitor_enable_bit) |-> !monitor_output_pin
    && !monitor_pin_hiz && !monitor_undefined) else $error("monitor active while off");
  last_chan_a: assert property (last_channel_output != monitor_enable_bit)
    else $error("last channel role wrong");
  thermal_off_a: assert property (thermal_shutdown_enable_bit && over_temp |=> amps_off)
    else $error("no thermal shutdown");
  toggle_flip_a: assert property ($fell(load_strobe_n) && !cmd_valid |=>
    toggle_group_uses_b == ($past(toggle_group_uses_b) ^ $past(toggle_group_enables)))
    else $error("toggle flip wrong");
  ab_select_a: assert property (cmd_valid && !cmd_read && cmd_sel != 2'h0
    && cmd_addr < CHANNELS && !blocked |=> data_wr
    && data_wr_b == $past(cmd_ab_b && toggle_group_enables[cmd_addr[5:3]]))
    else $error("a/b steering wrong");
endmodule
bind dcm_ctrl dcm_ctrl_checker #(.CHANNELS(CHANNELS)) i_dcm_ctrl_checker (.*);
`default_nettype wire

// ===== dcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcm_host_model (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic cmd_read,
  output logic cmd_ab_b,
  output logic [5:0] cmd_addr,
  output logic [1:0] cmd_sel,
  output logic [11:0] cmd_data
);
  // Idle bus before the first command
  initial
  begin
    {cmd_valid, cmd_read, cmd_ab_b, cmd_addr, cmd_sel, cmd_data} = '0;
  end
  // One command held across one sampling edge, then stale address and data fields scrambled
  task automatic send(input logic [1:0] sel, input logic [5:0] addr, input logic rd,
    input logic ab, input logic [11:0] data);
    @(negedge core_clk);
    {cmd_sel, cmd_addr, cmd_read, cmd_ab_b, cmd_data} = {sel, addr, rd, ab, data};
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    {cmd_addr, cmd_data} = ~{cmd_addr, cmd_data};
  endtask
endmodule
`default_nettype wire

// ===== tb_dac_control_and_monitor_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_control_and_monitor_select;
  typedef struct packed {logic [11:0] wr; logic [10:0] bits;} dcm_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic load_strobe_n = 1'b1;
  logic hw_powerdown = 1'b0;
  logic over_temp = 1'b0;
  logic cmd_valid, cmd_read, cmd_ab_b, rd_valid, cmd_refused, data_wr, data_wr_b, amps_off;
  logic [5:0] cmd_addr, data_wr_channel, monitor_channel_address;
  logic [1:0] cmd_sel, data_wr_sel;
  logic [11:0] cmd_data, rd_data, data_wr_value;
  logic powerdown_output_state_bit, internal_ref_level_bit, amp_boost_bit, ref_source_bit;
  logic monitor_enable_bit, thermal_shutdown_enable_bit, last_channel_output;
  logic monitor_output_pin, monitor_pin_hiz, monitor_undefined;
  logic [4:0] toggle_group_enables, toggle_group_uses_b;
  logic [10:0] ctrl_bits;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  dcm_row_t rows [4] = '{'{12'hfff, 11'h7ff}, '{12'h020, 11'h000}, '{12'h5ca, 11'h2ea},
    '{12'h000, 11'h000}};
  logic [5:0] mon_addr [5] = '{6'h00, 6'h26, 6'h27, 6'h3e, 6'h3f};
  assign ctrl_bits = {powerdown_output_state_bit, internal_ref_level_bit, amp_boost_bit,
    ref_source_bit, monitor_enable_bit, thermal_shutdown_enable_bit, toggle_group_enables};
  dcm_ctrl #(.CHANNELS(40), .REF_LEVEL_DEFAULT(1'b1)) i_dcm_ctrl (.*);
  dcm_host_model i_dcm_host_model (.*);
  always #2.5 core_clk = ~core_clk;
  // Compare helpers
  task automatic chk_word(input string name, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_word(name, {11'h0, exp}, {11'h0, got});
  endtask
  task automatic send(input logic [1:0] sel, input logic [5:0] addr, input logic rd,
    input logic ab, input logic [11:0] data);
    i_dcm_host_model.send(sel, addr, rd, ab, data);
  endtask
  task automatic rd_ctrl(input logic [11:0] exp);
    send(2'h0, 6'h0c, 1'b1, 1'b0, 12'h0);
    chk_bit("rd_valid", 1'b1, rd_valid);
    chk_word("rd_data", exp, rd_data);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    foreach (rows[i])
    begin
      send(2'h0, 6'h0c, 1'b0, 1'b0, rows[i].wr);
      chk_word("ctrl_bits", {1'b0, rows[i].bits}, {1'b0, ctrl_bits});
      rd_ctrl(rows[i].wr);
    end
    $display("done: table");
    send(2'h0, 6'h0c, 1'b0, 1'b0, 12'h080);
    chk_bit("last_channel", 1'b0, last_channel_output);
    foreach (mon_addr[i])
    begin
      send(2'h0, 6'h0a, 1'b0, 1'b0, {mon_addr[i], 6'h3f});
      @(negedge core_clk);
      chk_word("mon_addr", {6'h0, mon_addr[i]}, {6'h0, monitor_channel_address});
      chk_bit("mon_route", mon_addr[i] <= 6'h26, monitor_output_pin);
      chk_bit("mon_hiz", mon_addr[i] == 6'h3f, monitor_pin_hiz);
      chk_bit("mon_undef", mon_addr[i] inside {[6'h27:6'h3e]}, monitor_undefined);
    end
    send(2'h0, 6'h0c, 1'b0, 1'b0, 12'h015);
    @(negedge core_clk);
    chk_bit("mon_off_hiz", 1'b0, monitor_pin_hiz);
    chk_bit("last_channel", 1'b1, last_channel_output);
    $display("done: monitor");
    send(2'h3, 6'd33, 1'b0, 1'b1, 12'h123);
    chk_bit("ab_group4", 1'b1, data_wr_b);
    chk_bit("data_wr", 1'b1, data_wr);
    chk_bit("not_refused", 1'b0, cmd_refused);
    chk_word("wr_channel", 12'h021, {6'h0, data_wr_channel});
    chk_word("wr_sel", 12'h003, {10'h0, data_wr_sel});
    chk_word("wr_value", 12'h123, data_wr_value);
    send(2'h3, 6'd9, 1'b0, 1'b1, 12'h321);
    chk_bit("ab_group1", 1'b0, data_wr_b);
    for (int i = 0; i < 2; i++)
    begin
      load_strobe_n = 1'b0;
      repeat (2) @(negedge core_clk);
      load_strobe_n = 1'b1;
      chk_word("uses_b", (i == 0) ? 12'h015 : 12'h000, {7'h0, toggle_group_uses_b});
      @(negedge core_clk);
    end
    $display("done: toggle");
    send(2'h0, 6'h08, 1'b0, 1'b0, 12'h0);
    chk_bit("soft_down", 1'b1, amps_off);
    send(2'h0, 6'h0c, 1'b0, 1'b0, 12'hfff);
    chk_bit("refused", 1'b1, cmd_refused);
    send(2'h0, 6'h0a, 1'b0, 1'b0, 12'h000);
    chk_bit("mon_refused", 1'b1, cmd_refused);
    send(2'h3, 6'h01, 1'b0, 1'b0, 12'h456);
    chk_bit("data_refused", 1'b1, cmd_refused);
    chk_bit("no_data_wr", 1'b0, data_wr);
    @(negedge core_clk);
    chk_word("mon_kept", 12'h03f, {6'h0, monitor_channel_address});
    rd_ctrl(12'h015);
    send(2'h0, 6'h09, 1'b0, 1'b0, 12'h0);
    chk_bit("soft_up", 1'b0, amps_off);
    hw_powerdown = 1'b1;
    send(2'h0, 6'h0c, 1'b0, 1'b0, 12'hfff);
    chk_bit("hw_refused", 1'b1, cmd_refused);
    hw_powerdown = 1'b0;
    rd_ctrl(12'h015);
    $display("done: power-down");
    send(2'h0, 6'h0c, 1'b0, 1'b0, 12'h040);
    over_temp = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_bit("thermal_off", 1'b1, amps_off);
    send(2'h0, 6'h09, 1'b0, 1'b0, 12'h0);
    chk_bit("hot_up", 1'b1, amps_off);
    over_temp = 1'b0;
    send(2'h0, 6'h09, 1'b0, 1'b0, 12'h0);
    chk_bit("cool_up", 1'b0, amps_off);
    $display("done: thermal");
    rst = 1'b1;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    rd_ctrl(12'hc00);
    chk_bit("last_channel", 1'b1, last_channel_output);
    $display("done: reset");
    print_verdict();
  end
endmodule
`default_nettype wire
